/* dv/iep_regs_props.sv */
`timescale 1ns/100ps
`include "iep_defines.svh"

// Watches gating, masking, error and reset behaviour at the block ports.
module iep_regs_props #(
   parameter int ADDR_W = 12,
   parameter bit HAS_CAN = 1'b1
) (
   // Clock, reset and bus.
   input wire logic clk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   // Sources and results.
   input wire iep_pkg::iep_word_t evt1,
   input wire iep_pkg::iep_word_t arb_req0,
   input wire iep_pkg::iep_word_t arb_req1,
   input wire iep_pkg::iep_word_t arb_req2,
   input wire iep_pkg::iep_word_t arb_req3,
   input wire iep_pkg::iep_word_t arb_req4,
   input wire iep_pkg::iep_level_t timer1_prio,
   input wire iep_pkg::iep_level_t compare1_prio,
   input wire iep_pkg::iep_level_t capture1_prio,
   input wire iep_pkg::iep_level_t ext_irq0_prio,
   input wire iep_pkg::iep_level_t pend_level,
   input wire logic [1:0] pend_src,
   input wire logic irq
);
   import iep_pkg::*;
   logic acc; // Access phase of a transfer.
   logic unmapped; // Address outside the register map.
   assign acc = psel && penable;
   assign unmapped = !((paddr < 'h18) || ((paddr >= 'h20) && (paddr < 'h38)));
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   a_irq_any_req: assert property (irq == |{arb_req0, arb_req1, arb_req2, arb_req3, arb_req4})
      else $error("irq does not follow the requests");
   a_req_impl_only: assert property (((arb_req2 & ~16'h601F) | (arb_req3 & ~16'h6000)) == 16'h0000)
      else $error("request on an unimplemented bit");
   a_read_upper_zero: assert property (acc |-> prdata[31:16] == 16'h0000)
      else $error("upper read data not zero");
   a_unmapped_err: assert property (acc |-> pslverr == unmapped)
      else $error("error response wrong for address");
   a_can_dead: assert property (!HAS_CAN |-> arb_req2[3:2] == 2'b00 && !arb_req4[6])
      else $error("missing controller source requests");
   a_prio_zero_off: assert property (!(ext_irq0_prio == 3'h0 && arb_req0[0]) && !(timer1_prio == 3'h0 && arb_req0[3]))
      else $error("disabled priority still requests");
   a_pend_follows: assert property (arb_req0[3:0] == 4'h1 |=> pend_level == $past(ext_irq0_prio) && pend_src == 2'd0)
      else $error("pending level wrong");
   a_req_has_cause: assert property ($rose(arb_req1[0]) |-> $past(evt1[0]) || $past(acc && pwrite))
      else $error("request rose without cause");
   a_reset_fields: assert property ($rose(rst_b) |-> {timer1_prio, compare1_prio, capture1_prio, ext_irq0_prio} == 12'h924)
      else $error("priority fields wrong after reset");
   c_irq: cover property (irq);
   c_err: cover property (acc && pslverr);
   c_top: cover property (pend_level == 3'h7);
endmodule : iep_regs_props

bind iep_regs iep_regs_props #(.ADDR_W(ADDR_W), .HAS_CAN(HAS_CAN)) iep_regs_props_inst (.clk, .rst_b, .psel,
   .penable, .pwrite, .paddr, .prdata, .pslverr, .evt1, .arb_req0, .arb_req1, .arb_req2, .arb_req3, .arb_req4,
   .timer1_prio, .compare1_prio, .capture1_prio, .ext_irq0_prio, .pend_level, .pend_src, .irq);

/* dv/iep_src_model.sv */
`timescale 1ns/100ps

// Peripheral sources: one-cycle event pulses, one bit per source, any bits of one group per pulse.
module iep_src_model (
   // Clock.
   input wire logic clk,
   // Event pulses.
   output iep_pkg::iep_word_t evt0,
   output iep_pkg::iep_word_t evt1,
   output iep_pkg::iep_word_t evt2,
   output iep_pkg::iep_word_t evt3,
   output iep_pkg::iep_word_t evt4
);
   import iep_pkg::*;
   iep_bank_t evt_ff = '0; // Pulse state of all groups.
   assign {evt4, evt3, evt2, evt1, evt0} = evt_ff;
   // Raises the given bits of one group for exactly one cycle.
   task pulse(input int idx, input iep_word_t mask);
      @(posedge clk);
      evt_ff[idx] <= mask;
      @(posedge clk);
      evt_ff[idx] <= 16'h0000;
   endtask : pulse
endmodule : iep_src_model

/* dv/interrupt_enable_priority_regs_bench.sv */
`timescale 1ns/100ps

// Register-level tests of the enable and priority block.
module interrupt_enable_priority_regs_bench;
   import iep_pkg::*;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, irq, err;
   iep_word_t evt0, evt1, evt2, evt3, evt4, arb_req0, arb_req1, arb_req2, arb_req3, arb_req4, rd;
   iep_level_t timer1_prio, compare1_prio, capture1_prio, ext_irq0_prio, pend_level;
   logic [1:0] pend_src;
   iep_bank_t req; // All request groups, indexed like the registers.
   int err_total = 0, checks_done = 0;
   iep_word_t impl [5] = '{16'h7FFF, 16'hFFDF, 16'h601F, 16'h6000, 16'h007E}; // Writable bits.
   iep_word_t gated [5] = '{16'h0000, 16'hFFDF, 16'h6013, 16'h6000, 16'h003E}; // Live requests.
   assign req = {arb_req4, arb_req3, arb_req2, arb_req1, arb_req0};
   always #4 clk = ~clk;
   // Device without the CAN controller.
   iep_regs #(.HAS_CAN(1'b0)) iep_regs_inst (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pstrb(4'hF), .prdata, .pready, .pslverr, .evt0, .evt1, .evt2, .evt3, .evt4, .arb_req0, .arb_req1,
      .arb_req2, .arb_req3, .arb_req4, .timer1_prio, .compare1_prio, .capture1_prio, .ext_irq0_prio,
      .pend_level, .pend_src, .irq);
   iep_src_model iep_src_model_inst (.clk, .evt0, .evt1, .evt2, .evt3, .evt4);
   // Compares one value and counts the result.
   task cmp16(input string what, input iep_word_t exp, input iep_word_t got);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp16
   // One APB transfer; upper write data is junk that must be ignored.
   task apb(input logic wr, input logic [11:0] addr, input iep_word_t data);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= {16'hFFFF, data};
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata[15:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Prints the counts and the verdict, then stops.
   task test_done;
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : test_done
   // Watchdog against a hung transfer.
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      test_done();
   end
   // Main test sequence.
   initial begin
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, 12'(4 * i), 16'h0000);
         cmp16("enable reset", 16'h0000, rd);
         apb(1'b1, 12'(4 * i), 16'hFFFF);
         apb(1'b0, 12'(4 * i), 16'h0000);
         cmp16("enable bits", impl[i], rd);
      end
      apb(1'b0, 12'h014, 16'h0000);
      cmp16("prio reset", 16'h4444, rd);
      apb(1'b1, 12'h014, 16'hFFFF);
      apb(1'b0, 12'h014, 16'h0000);
      cmp16("prio bits", 16'h7777, rd);
      apb(1'b1, 12'h014, 16'h7531);
      #1 cmp16("prio fields", 16'h7531, {1'b0, timer1_prio, 1'b0, compare1_prio, 1'b0, capture1_prio, 1'b0,
         ext_irq0_prio});
      apb(1'b0, 12'h018, 16'h0000);
      cmp16("unmapped read", 16'h0001, {rd[14:0], err});
      $display("test registers done");
      apb(1'b1, 12'h000, 16'h0000);
      iep_src_model_inst.pulse(0, 16'h0001);
      #1 cmp16("masked request", 16'h0000, arb_req0);
      apb(1'b0, 12'h020, 16'h0000);
      cmp16("flag held", 16'h0001, rd);
      apb(1'b1, 12'h000, 16'h000F);
      for (int code = 0; code < 8; code++) begin
         apb(1'b1, 12'h014, 16'(code));
         iep_src_model_inst.pulse(0, 16'h0001);
         #1 cmp16("ext0 request", 16'(code != 0), arb_req0);
         @(posedge clk);
         #1 if (code != 0) cmp16("pend level", 16'(code), 16'(pend_level));
         apb(1'b1, 12'h020, 16'h0001);
         apb(1'b0, 12'h020, 16'h0000);
         cmp16("flag clear", 16'h0000, rd);
      end
      apb(1'b1, 12'h014, 16'h3751);
      iep_src_model_inst.pulse(0, 16'h000F);
      @(posedge clk);
      #1 cmp16("pend winner", 16'h0027, {10'h0, pend_src, 1'b0, pend_level});
      $display("test priority done");
      for (int i = 1; i < 5; i++) begin
         iep_src_model_inst.pulse(i, 16'hFFFF);
         #1 cmp16("gated group", gated[i], req[i]);
         apb(1'b0, 12'(32 + 4 * i), 16'h0000);
         cmp16("flag group", impl[i], rd);
      end
      cmp16("irq level", 16'h0001, 16'(irq));
      apb(1'b1, 12'h024, 16'hFFFF);
      #1 cmp16("group1 cleared", 16'h0000, arb_req1);
      $display("test sources done");
      test_done();
   end
endmodule : interrupt_enable_priority_regs_bench

/* hdl/iep_defines.svh */
`ifndef IEP_DEFINES_SVH
`define IEP_DEFINES_SVH

// Register byte offsets on the APB bus.
`define IEP_OFF_EN0 12'h000
`define IEP_OFF_EN1 12'h004
`define IEP_OFF_EN2 12'h008
`define IEP_OFF_EN3 12'h00C
`define IEP_OFF_EN4 12'h010
`define IEP_OFF_PRIO0 12'h014
`define IEP_OFF_FLAG0 12'h020
`define IEP_OFF_FLAG1 12'h024
`define IEP_OFF_FLAG2 12'h028
`define IEP_OFF_FLAG3 12'h02C
`define IEP_OFF_FLAG4 12'h030
`define IEP_OFF_PEND 12'h034

// Implemented bits of each enable and flag register.
`define IEP_IMPL0 16'h7FFF
`define IEP_IMPL1 16'hFFDF
`define IEP_IMPL2 16'h601F
`define IEP_IMPL3 16'h6000
`define IEP_IMPL4 16'h007E

// Implemented bits and reset value of the priority register.
`define IEP_PRIO_IMPL 16'h7777
`define IEP_PRIO_RST 16'h4444

// Sources that belong to the CAN controller.
`define IEP_CAN_BITS2 16'h000C
`define IEP_CAN_BITS4 16'h0040

// Priority field geometry.
`define IEP_PRIO_W 3
`define IEP_PRIO_STRIDE 4
`define IEP_PRIO_FIELDS 4
`define IEP_PRIO_OFF 3'h0
`define IEP_PRIO_TOP 3'h7

// Layout of the pending summary register.
`define IEP_PEND_LVL_LSB 0
`define IEP_PEND_SRC_LSB 4
`define IEP_PEND_IRQ_BIT 8

`endif

/* hdl/iep_gate.sv */
`timescale 1ns/100ps

// Per-bit gating of raised flags by enables and extra qualifiers.
module iep_gate #(
   parameter int WIDTH = 16
) (
   // Raised request flags.
   input wire logic [WIDTH-1:0] flag,
   // Software enables.
   input wire logic [WIDTH-1:0] en,
   // Other qualifiers (priority nonzero, variant present).
   input wire logic [WIDTH-1:0] allow,
   // Requests handed on to arbitration.
   output logic [WIDTH-1:0] req
);
   import iep_pkg::*;

   // Refuse a width that cannot hold anything.
   if (WIDTH < 1) begin : g_bad_width
      $error("iep_gate: WIDTH must be at least 1.");
   end

   // One gate per source bit.
   for (genvar b = 0; b < WIDTH; b++) begin : g_bit
      assign req[b] = flag[b] & en[b] & allow[b];
   end

endmodule : iep_gate

/* hdl/iep_pkg.sv */
package iep_pkg;

   // One 16-bit register word.
   typedef logic [15:0] iep_word_t;

   // A priority level, 0 meaning disabled.
   typedef logic [2:0] iep_level_t;

   // The five enable or flag registers as one array.
   typedef logic [4:0][15:0] iep_bank_t;

   // All state of the register block.
   typedef struct packed {
      iep_bank_t en;
      iep_word_t prio;
      iep_bank_t flag;
      logic [31:0] prdata;
      logic pslverr;
      iep_level_t pend_level;
      logic [1:0] pend_src;
   } iep_state_t;

endpackage : iep_pkg

/* hdl/iep_prio_dec.sv */
`timescale 1ns/100ps
`include "iep_defines.svh"

// Decodes one 3-bit priority field into a level and an active flag.
module iep_prio_dec (
   // Field value.
   input wire iep_pkg::iep_level_t field,
   // Decoded result.
   output iep_pkg::iep_level_t level,
   output logic active
);
   import iep_pkg::*;

   // Codes 001 to 111 map straight onto levels 1 to 7.
   assign level = field;

   // Code 000 removes the source from arbitration.
   assign active = (field != `IEP_PRIO_OFF);

endmodule : iep_prio_dec

/* hdl/iep_regs.sv */
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/100ps
`include "iep_defines.svh"

// Overview of operation
// - Enable one passes request, zero blocks it.
// - Unimplemented bits read zero, ignore writes.
// - Priority code 111 is level seven.
// - Priority code 000 disables the source.
// - Codes 001 to 110 give levels one-six.
// - Priority register holds four three-bit fields.
// - Enables reset zero, priorities reset to 4444.
// - Enable register one source bit layout.
// - Enable register two source bit layout.
// - Enable register three: calendar and DMA5.
// - Enable register four source bit layout.
// - Enable register zero low fifteen bits.
// - CAN sources dead on variants without CAN.
// - Flag bits sit where their enables sit.
module iep_regs #(
   parameter int ADDR_W = 12,
   parameter bit HAS_CAN = 1'b1
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_b,
   // APB slave port.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Source event pulses, one group per register.
   input wire iep_pkg::iep_word_t evt0,
   input wire iep_pkg::iep_word_t evt1,
   input wire iep_pkg::iep_word_t evt2,
   input wire iep_pkg::iep_word_t evt3,
   input wire iep_pkg::iep_word_t evt4,
   // Requests handed to arbitration, one group per register.
   output iep_pkg::iep_word_t arb_req0,
   output iep_pkg::iep_word_t arb_req1,
   output iep_pkg::iep_word_t arb_req2,
   output iep_pkg::iep_word_t arb_req3,
   output iep_pkg::iep_word_t arb_req4,
   // Priority fields handed to arbitration.
   output iep_pkg::iep_level_t timer1_prio,
   output iep_pkg::iep_level_t compare1_prio,
   output iep_pkg::iep_level_t capture1_prio,
   output iep_pkg::iep_level_t ext_irq0_prio,
   // Highest pending level among the four prioritised sources.
   output iep_pkg::iep_level_t pend_level,
   output logic [1:0] pend_src,
   // Summary interrupt.
   output logic irq
);
   import iep_pkg::*;

   // Refuse an address bus too narrow for the map.
   if (ADDR_W < 8) begin : g_bad_addr
      $error("iep_regs: ADDR_W must be at least 8.");
   end

   // Reset value of the whole state.
   localparam iep_state_t STATE_RST = '{
      en: '0,
      prio: `IEP_PRIO_RST,
      flag: '0,
      prdata: '0,
      pslverr: 1'b0,
      pend_level: '0,
      pend_src: '0
   };

   // Implemented bits per enable and flag register.
   localparam iep_bank_t IMPL = {
      `IEP_IMPL4,
      `IEP_IMPL3,
      `IEP_IMPL2,
      `IEP_IMPL1,
      `IEP_IMPL0
   };

   // Registered state and its next value.
   iep_state_t state_ff;
   iep_state_t nxt_state;

   // Events collected into one bank.
   iep_bank_t evt_bank;
   // Qualifiers beside the enable.
   iep_bank_t allow_bank;
   // Gated requests.
   iep_bank_t req_bank;
   // Decoded priority levels and active flags.
   iep_level_t [`IEP_PRIO_FIELDS-1:0] prio_lvl;
   logic [`IEP_PRIO_FIELDS-1:0] prio_act;
   // Variant mask for the CAN sources.
   iep_bank_t can_ok;

   // Byte-lane write mask for the low half word.
   iep_word_t lane_mask;
   // Decoded access phases.
   logic setup_ph;
   logic wr_acc;
   // Word address with the byte bits dropped.
   logic [ADDR_W-1:0] word_addr;

   // Pack the event inputs.
   assign evt_bank = {evt4, evt3, evt2, evt1, evt0};

   // The slave never inserts wait states.
   assign pready = 1'b1;

   // Setup phase and completed write.
   assign setup_ph = psel & ~penable;
   assign wr_acc = psel & penable & pwrite;
   assign word_addr = {paddr[ADDR_W-1:2], 2'b00};

   // Only lanes 0 and 1 carry register bits.
   assign lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

   // Without the CAN controller its three sources never fire.
   assign can_ok[0] = '1;
   assign can_ok[1] = '1;
   assign can_ok[2] = HAS_CAN ? '1 : ~`IEP_CAN_BITS2;
   assign can_ok[3] = '1;
   assign can_ok[4] = HAS_CAN ? '1 : ~`IEP_CAN_BITS4;

   // One decoder per priority field; field k sits at bit 4k.
   for (genvar k = 0; k < `IEP_PRIO_FIELDS; k++) begin : g_prio
      iep_prio_dec u_dec (
         .field(state_ff.prio[k*`IEP_PRIO_STRIDE +: `IEP_PRIO_W]),
         .level(prio_lvl[k]),
         .active(prio_act[k])
      );
   end

   // Sources with a priority field need it nonzero.
   assign allow_bank[0] = can_ok[0] & {12'hFFF, prio_act};
   assign allow_bank[1] = can_ok[1];
   assign allow_bank[2] = can_ok[2];
   assign allow_bank[3] = can_ok[3];
   assign allow_bank[4] = can_ok[4];

   // One gate instance per register group.
   for (genvar g = 0; g < 5; g++) begin : g_grp
      iep_gate #(
         .WIDTH(16)
      ) u_gate (
         .flag(state_ff.flag[g]),
         .en(state_ff.en[g]),
         .allow(allow_bank[g]),
         .req(req_bank[g])
      );
   end

   // Requests go to arbitration.
   assign arb_req0 = req_bank[0];
   assign arb_req1 = req_bank[1];
   assign arb_req2 = req_bank[2];
   assign arb_req3 = req_bank[3];
   assign arb_req4 = req_bank[4];

   // Fields come straight from the priority register.
   assign ext_irq0_prio = state_ff.prio[0 +: `IEP_PRIO_W];
   assign capture1_prio = state_ff.prio[4 +: `IEP_PRIO_W];
   assign compare1_prio = state_ff.prio[8 +: `IEP_PRIO_W];
   assign timer1_prio = state_ff.prio[12 +: `IEP_PRIO_W];

   // Bus and summary outputs come from the state.
   assign prdata = state_ff.prdata;
   assign pslverr = state_ff.pslverr;
   assign pend_level = state_ff.pend_level;
   assign pend_src = state_ff.pend_src;

   // Interrupt is high while any gated request stands.
   assign irq = |req_bank;

   // Next state: flags, register writes, read capture, pending level.
   always_comb begin
      iep_word_t wmask;
      iep_word_t wdat;
      iep_level_t best;
      logic [1:0] best_src;
      logic hit;
      logic [31:0] rdat;
      wmask = '0;
      wdat = '0;
      best = '0;
      best_src = '0;
      hit = 1'b0;
      rdat = '0;
      nxt_state = state_ff;
      wdat = pwdata[15:0];
      wmask = lane_mask;

      // Flags: write one clears, a new event wins over the clear.
      for (int g = 0; g < 5; g++) begin
         if (wr_acc && word_addr == (`IEP_OFF_FLAG0 + ADDR_W'(4 * g))) begin
            nxt_state.flag[g] = state_ff.flag[g] & ~(wdat & wmask);
         end
         nxt_state.flag[g] = (nxt_state.flag[g] | evt_bank[g]) & IMPL[g];
      end

      // Enable and priority writes keep only implemented bits.
      if (wr_acc) begin
         for (int g = 0; g < 5; g++) begin
            if (word_addr == (`IEP_OFF_EN0 + ADDR_W'(4 * g))) begin
               nxt_state.en[g] = ((state_ff.en[g] & ~wmask) | (wdat & wmask)) & IMPL[g];
            end
         end
         if (word_addr == `IEP_OFF_PRIO0) begin
            nxt_state.prio = ((state_ff.prio & ~wmask) | (wdat & wmask)) & `IEP_PRIO_IMPL;
         end
      end

      // Read data is captured in the setup phase.
      if (setup_ph) begin
         hit = 1'b0;
         for (int g = 0; g < 5; g++) begin
            if (word_addr == (`IEP_OFF_EN0 + ADDR_W'(4 * g))) begin
               rdat = {16'h0000, state_ff.en[g]};
               hit = 1'b1;
            end
            if (word_addr == (`IEP_OFF_FLAG0 + ADDR_W'(4 * g))) begin
               rdat = {16'h0000, state_ff.flag[g]};
               hit = 1'b1;
            end
         end
         if (word_addr == `IEP_OFF_PRIO0) begin
            rdat = {16'h0000, state_ff.prio};
            hit = 1'b1;
         end
         if (word_addr == `IEP_OFF_PEND) begin
            rdat = '0;
            rdat[`IEP_PEND_LVL_LSB +: 3] = state_ff.pend_level;
            rdat[`IEP_PEND_SRC_LSB +: 2] = state_ff.pend_src;
            rdat[`IEP_PEND_IRQ_BIT] = irq;
            hit = 1'b1;
         end
         // Unmapped addresses read zero and flag an error.
         nxt_state.prdata = hit ? rdat : '0;
         nxt_state.pslverr = ~hit;
      end

      // Highest gated level; on a tie the lower field wins.
      for (int k = `IEP_PRIO_FIELDS - 1; k >= 0; k--) begin
         if (req_bank[0][k] && prio_lvl[k] >= best) begin
            best = prio_lvl[k];
            best_src = 2'(k);
         end
      end
      nxt_state.pend_level = best;
      nxt_state.pend_src = best_src;
   end

   // Register the whole state.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_ff <= STATE_RST;
      end else begin
         state_ff <= nxt_state;
      end
   end

endmodule : iep_regs
